// file: event_status_consts.vh
// constants for the instrument event and status register bank
// assumes it is included by its bare name from the bank module
`ifndef EVENT_STATUS_CONSTS_VH
`define EVENT_STATUS_CONSTS_VH

// query selector codes
`define SEL_EVT_LATCH     4'h0
`define SEL_EVT_MASK      4'h1
`define SEL_ACT_COND      4'h2
`define SEL_ACT_EVENT     4'h3
`define SEL_ACT_ENABLE    4'h4
`define SEL_SUS_COND      4'h5
`define SEL_SUS_EVENT     4'h6
`define SEL_SUS_ENABLE    4'h7
`define SEL_TB_COND       4'h8
`define SEL_TB_EVENT      4'h9
`define SEL_TB_ENABLE     4'hA

// event status latch bit positions
`define EVT_OPC_BIT       0
`define EVT_QUERY_BIT     2
`define EVT_DEVICE_BIT    3
`define EVT_EXEC_BIT      4
`define EVT_CMD_BIT       5
`define EVT_POWER_BIT     7

// activity register bit positions
`define ACT_ALIGN_BIT     0

// suspect register bit positions
`define SUS_BATT_BIT      2
`define SUS_TEMP_BIT      4
`define SUS_LIMIT_BIT     9
`define SUS_UNALIGN_BIT   10

// timebase register bit positions
`define TB_EXTREF_BIT     8

// masks of implemented bits, bit 15 never included
`define EVT_USED_MASK     8'hBD
`define ACT_USED_MASK     16'h0001
`define SUS_USED_MASK     16'h0614
`define TB_USED_MASK      16'h0100

// enable parts take every bit but bit 15
`define ENABLE_WRITE_MASK 16'h7FFF

// reset values
`define EVT_LATCH_RESET   8'h80
`define EVT_MASK_RESET    8'h00
`define STAT_RESET        16'h0000

// error codes logged toward the error queue (two's complement)
`define ERR_CODE_DEVICE   16'hFED4
`define ERR_CODE_EXEC     16'hFF38
`define ERR_CODE_CMD      16'hFF9C
`define ERR_CODE_NONE     16'h0000

`endif

// file: instrument_event_status_regs.v
// event status latch with its mask, plus activity, suspect and timebase
// status registers, each with condition, event and enable parts.
// assumes the command parser, the error sources and the condition sources
// all run on clk_sys; the parser issues one query per request pulse.
// conditions are not resynchronised here, so a source from another clock
// needs its own synchroniser in front of this bank.
//
// Behaviour
// - operation complete set once prior commands finish
// - query error bit on misordered read traffic
// - device error sets bit, logs device code
// - execution error sets bit, logs execution code unless a device error comes in the same cycle
// - command error sets bit, logs command code unless a device or execution error comes in the same cycle
// - power-on bit set by power-up reset
// - event status latch readable by query
// - eight-bit event mask written and read back
// - condition shows now, event shows since read
// - activity bit 0 follows alignment running
// - bit 15 of status registers reads zero
// - suspect bit 2 on battery low
// - suspect bit 4 on temperature trouble
// - suspect bit 9 on limit violation
// - suspect bit 10 on unaligned measurement
// - timebase bit 8 on external reference only
// - event summary from latch and mask
// - suspect summary from event and enable
// - activity summary from event and enable
`include "event_status_consts.vh"

module instrument_event_status_regs (
    // clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // query port from the command parser
    input  wire        qryValid,
    input  wire        qryWrite,
    input  wire [3:0]  qrySel,
    input  wire [15:0] qryWdata,
    output reg         rspValid,
    output reg  [15:0] rspData,
    // operation complete request and completion level
    input  wire        opcRequest,
    input  wire        allPriorDone,
    // query order errors, one-cycle pulses
    input  wire        readWithoutQuery,
    input  wire        dataNotFetched,
    // execution faults, one-cycle pulses
    input  wire        deviceFault,
    input  wire        execFault,
    input  wire        cmdFault,
    // instrument conditions, levels
    input  wire        alignment_running,
    input  wire        batteryLow,
    input  wire        tempSuspect,
    input  wire        limitViolated,
    input  wire        unaligned_label,
    input  wire        extRefUsed,
    // error queue entry toward the queue logic
    output reg         errLogValid,
    output reg  [15:0] errLogCode,
    // summary bits toward the status byte
    output wire        eventSummary,
    output wire        suspectSummary,
    output wire        activitySummary
);

    // event status latch and its mask
    reg [7:0]  event_status_latch;
    reg [7:0]  event_status_mask;

    // activity parts: event, enable, last condition
    reg [15:0] actEvent;
    reg [15:0] actEnable;
    reg [15:0] actPrev;

    // suspect parts: event, enable, last condition
    reg [15:0] susEvent;
    reg [15:0] susEnable;
    reg [15:0] susPrev;

    // timebase parts: event, enable, last condition
    reg [15:0] tbEvent;
    reg [15:0] tbEnable;
    reg [15:0] tbPrev;

    // operation complete waiting for earlier commands
    reg        opcPending;

    // next values
    reg [7:0]  next_latch;
    reg [15:0] next_rspData;
    reg [15:0] next_errCode;

    // decoded access strobes
    wire isRead  = qryValid & ~qryWrite;
    wire isWrite = qryValid & qryWrite;

    // event latch update: a set in the clearing cycle survives
    function [15:0] nextEvent;
        input [15:0] evt;
        input [15:0] cond;
        input [15:0] prev;
        input        clr;
        begin
            nextEvent = ((clr ? 16'h0000 : evt) | (cond & ~prev));
        end
    endfunction

    // selector hit test, shared by read and write decode
    function hit;
        input [3:0] sel;
        input [3:0] code;
        begin
            hit = (sel == code);
        end
    endfunction

    // read-clear strobes, one per event part
    wire clrLatch = isRead & hit(qrySel, `SEL_EVT_LATCH);
    wire clrAct   = isRead & hit(qrySel, `SEL_ACT_EVENT);
    wire clrSus   = isRead & hit(qrySel, `SEL_SUS_EVENT);
    wire clrTb    = isRead & hit(qrySel, `SEL_TB_EVENT);

    // write strobes; condition and event parts ignore writes
    wire wrMask   = isWrite & hit(qrySel, `SEL_EVT_MASK);
    wire wrAct    = isWrite & hit(qrySel, `SEL_ACT_ENABLE);
    wire wrSus    = isWrite & hit(qrySel, `SEL_SUS_ENABLE);
    wire wrTb     = isWrite & hit(qrySel, `SEL_TB_ENABLE);

    // condition parts, masked so unused bits and bit 15 stay zero
    wire [15:0] actRaw;
    wire [15:0] susRaw;
    wire [15:0] tbRaw;

    // activity condition: alignment in progress only
    assign actRaw[`ACT_ALIGN_BIT]   = alignment_running;
    assign actRaw[15:1]             = 15'h0000;

    // suspect condition: battery, temperature, limit, unaligned
    assign susRaw[1:0]              = 2'h0;
    assign susRaw[`SUS_BATT_BIT]    = batteryLow;
    assign susRaw[3]                = 1'b0;
    assign susRaw[`SUS_TEMP_BIT]    = tempSuspect;
    assign susRaw[8:5]              = 4'h0;
    assign susRaw[`SUS_LIMIT_BIT]   = limitViolated;
    assign susRaw[`SUS_UNALIGN_BIT] = unaligned_label;
    assign susRaw[15:11]            = 5'h00;

    // timebase condition: external reference only
    assign tbRaw[7:0]               = 8'h00;
    assign tbRaw[`TB_EXTREF_BIT]    = extRefUsed;
    assign tbRaw[15:9]              = 7'h00;

    wire [15:0] actCond = actRaw & `ACT_USED_MASK;
    wire [15:0] susCond = susRaw & `SUS_USED_MASK;
    wire [15:0] tbCond  = tbRaw & `TB_USED_MASK;

    // operation complete fires only while the parser reports all prior done
    wire opcFire  = (opcPending | opcRequest) & allPriorDone;

    // either misordered read case raises the query error
    wire queryErr = readWithoutQuery | dataNotFetched;

    // any fault pulse asks for one error queue entry
    wire anyFault = deviceFault | execFault | cmdFault;

    // event latch next value, read clears, fresh events win
    always @* begin
        next_latch = event_status_latch;
        if (clrLatch) begin
            next_latch = 8'h00;
        end
        if (opcFire) begin
            next_latch[`EVT_OPC_BIT] = 1'b1;
        end
        if (queryErr) begin
            next_latch[`EVT_QUERY_BIT] = 1'b1;
        end
        if (deviceFault) begin
            next_latch[`EVT_DEVICE_BIT] = 1'b1;
        end
        if (execFault) begin
            next_latch[`EVT_EXEC_BIT] = 1'b1;
        end
        if (cmdFault) begin
            next_latch[`EVT_CMD_BIT] = 1'b1;
        end
    end

    // one error code per cycle; device fault is the most severe
    always @* begin
        if (deviceFault) begin
            next_errCode = `ERR_CODE_DEVICE;
        end else if (execFault) begin
            next_errCode = `ERR_CODE_EXEC;
        end else if (cmdFault) begin
            next_errCode = `ERR_CODE_CMD;
        end else begin
            next_errCode = `ERR_CODE_NONE;
        end
    end

    // read multiplexer; writes and unmapped selectors answer zero
    always @* begin
        next_rspData = 16'h0000;
        if (isRead) begin
            case (qrySel)
                `SEL_EVT_LATCH:  next_rspData = {8'h00, event_status_latch};
                `SEL_EVT_MASK:   next_rspData = {8'h00, event_status_mask};
                `SEL_ACT_COND:   next_rspData = actCond;
                `SEL_ACT_EVENT:  next_rspData = actEvent;
                `SEL_ACT_ENABLE: next_rspData = actEnable;
                `SEL_SUS_COND:   next_rspData = susCond;
                `SEL_SUS_EVENT:  next_rspData = susEvent;
                `SEL_SUS_ENABLE: next_rspData = susEnable;
                `SEL_TB_COND:    next_rspData = tbCond;
                `SEL_TB_EVENT:   next_rspData = tbEvent;
                `SEL_TB_ENABLE:  next_rspData = tbEnable;
                default:         next_rspData = 16'h0000;
            endcase
        end
    end

    // power-up reset leaves the power-on bit set
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            event_status_latch <= `EVT_LATCH_RESET;
        end else begin
            event_status_latch <= next_latch & `EVT_USED_MASK;
        end
    end

    // an early request waits here until the parser reports all done
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            opcPending <= 1'b0;
        end else begin
            opcPending <= (opcPending | opcRequest) & ~allPriorDone;
        end
    end

    // event mask, all eight bits writable and read back
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            event_status_mask <= `EVT_MASK_RESET;
        end else if (wrMask) begin
            event_status_mask <= qryWdata[7:0];
        end
    end

    // activity enable; bit 15 is not writable
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            actEnable <= `STAT_RESET;
        end else if (wrAct) begin
            actEnable <= qryWdata & `ENABLE_WRITE_MASK;
        end
    end

    // suspect enable; bit 15 is not writable
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            susEnable <= `STAT_RESET;
        end else if (wrSus) begin
            susEnable <= qryWdata & `ENABLE_WRITE_MASK;
        end
    end

    // timebase enable; no summary uses it here, kept for read-back
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tbEnable <= `STAT_RESET;
        end else if (wrTb) begin
            tbEnable <= qryWdata & `ENABLE_WRITE_MASK;
        end
    end

    // activity event part: rising condition latches, read clears
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            actEvent <= `STAT_RESET;
            actPrev  <= `STAT_RESET;
        end else begin
            actEvent <= nextEvent(actEvent, actCond, actPrev, clrAct);
            actPrev  <= actCond;
        end
    end

    // suspect event part; a rise in the read cycle is not lost
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            susEvent <= `STAT_RESET;
            susPrev  <= `STAT_RESET;
        end else begin
            susEvent <= nextEvent(susEvent, susCond, susPrev, clrSus);
            susPrev  <= susCond;
        end
    end

    // timebase event part, external reference edge only
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tbEvent <= `STAT_RESET;
            tbPrev  <= `STAT_RESET;
        end else begin
            tbEvent <= nextEvent(tbEvent, tbCond, tbPrev, clrTb);
            tbPrev  <= tbCond;
        end
    end

    // answer one cycle after each query, data from flip-flops
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rspValid <= 1'b0;
            rspData  <= 16'h0000;
        end else begin
            rspValid <= qryValid;
            rspData  <= next_rspData;
        end
    end

    // error queue entry one cycle after the fault pulse
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            errLogValid <= 1'b0;
            errLogCode  <= `ERR_CODE_NONE;
        end else begin
            errLogValid <= anyFault;
            errLogCode  <= next_errCode;
        end
    end

    // enabled event bits, one reduction per summary
    wire [7:0]  evtHits = event_status_latch & event_status_mask;
    wire [15:0] susHits = susEvent & susEnable;
    wire [15:0] actHits = actEvent & actEnable;

    // summaries are combinational so the status byte sees them at once
    assign eventSummary    = |evtHits;
    assign suspectSummary  = |susHits;
    assign activitySummary = |actHits;

endmodule

// file: instrument_event_status_regs_sva.sv
// port checks for the event and status register bank
// assumes one clock domain and a bind onto the bank
`include "event_status_consts.vh"
module instrument_event_status_regs_sva (
    // clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // query port
    input wire        qryValid,
    input wire        qryWrite,
    input wire [3:0]  qrySel,
    input wire [15:0] qryWdata,
    input wire        rspValid,
    input wire [15:0] rspData,
    // faults and error log
    input wire        deviceFault,
    input wire        execFault,
    input wire        cmdFault,
    input wire        errLogValid,
    input wire [15:0] errLogCode,
    // summary
    input wire        eventSummary
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // any fault pulse asks for one log entry
    wire anyFault = deviceFault | execFault | cmdFault;

    a_rsp_follows: assert property (qryValid |=> rspValid) else $error("no answer");
    a_rsp_quiet: assert property (!qryValid |=> !rspValid && rspData == 16'h0000) else $error("stray answer");
    a_top_bit: assert property (rspValid |-> !rspData[15]) else $error("bit 15 set");
    a_write_ack: assert property (qryValid && qryWrite |=> rspData == 16'h0000) else $error("write data");
    a_log_pulse: assert property (anyFault |=> errLogValid) else $error("no log");
    a_log_idle: assert property (!anyFault |=> !errLogValid) else $error("stray log");
    a_dev_code: assert property (deviceFault |=> errLogCode == `ERR_CODE_DEVICE) else $error("dev code");
    a_exec_code: assert property (execFault && !deviceFault |=> errLogCode == `ERR_CODE_EXEC)
        else $error("exec code");
    a_cmd_code: assert property (cmdFault && !execFault && !deviceFault |=> errLogCode == `ERR_CODE_CMD)
        else $error("cmd code");
    a_mask_off: assert property (qryValid && qryWrite && qrySel == `SEL_EVT_MASK && qryWdata[7:0] == 8'h00
        |=> !eventSummary) else $error("summary with mask off");
    c_write: cover property (qryValid && qryWrite);
    c_fault: cover property (deviceFault && execFault);
    c_summary: cover property (eventSummary);
endmodule

bind instrument_event_status_regs instrument_event_status_regs_sva i_sva (
    .clk_sys(clk_sys), .resetn(resetn), .qryValid(qryValid), .qryWrite(qryWrite), .qrySel(qrySel),
    .qryWdata(qryWdata), .rspValid(rspValid), .rspData(rspData), .deviceFault(deviceFault),
    .execFault(execFault), .cmdFault(cmdFault), .errLogValid(errLogValid), .errLogCode(errLogCode),
    .eventSummary(eventSummary));

// file: host_ctrl.sv
// host controller model issuing one query per call
// assumes the bank answers on the same edge that takes the query
module host_ctrl (
    // clock
    input  wire         clk_sys,
    // query port
    output logic        qryValid,
    output logic        qryWrite,
    output logic [3:0]  qrySel,
    output logic [15:0] qryWdata,
    input  wire         rspValid,
    input  wire  [15:0] rspData
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle port at time zero
    initial begin
        qryValid = 1'b0;
        qryWrite = 1'b0;
        qrySel = 4'h0;
        qryWdata = 16'h0000;
    end
    // qualifiers inverted after the answer so stale values are never trusted
    task automatic access(input logic wr, input logic [3:0] sel, input logic [15:0] wd,
                          output logic [15:0] rd, output logic ok);
        @(posedge clk_sys);
        #1;
        qryValid = 1'b1;
        qryWrite = wr;
        qrySel = sel;
        qryWdata = wd;
        @(posedge clk_sys);
        #1;
        qryValid = 1'b0;
        qryWrite = ~wr;
        qrySel = ~sel;
        qryWdata = ~wd;
        rd = rspData;
        ok = rspValid;
    endtask
endmodule

// file: instrument_event_status_regs_test.sv
// self-checking bench for the event and status register bank
// assumes the host model drives queries, the bench drives events and conditions
`include "event_status_consts.vh"
module instrument_event_status_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys, resetn, qryValid, qryWrite, rspValid, allPriorDone, errLogValid;
    logic        eventSummary, suspectSummary, activitySummary;
    logic [3:0]  qrySel;
    logic [15:0] qryWdata, rspData, errLogCode;
    logic [5:0]  pulses, conds;
    wire         opcRequest, readWithoutQuery, dataNotFetched, deviceFault, execFault, cmdFault;
    wire         alignment_running, batteryLow, tempSuspect, limitViolated, unaligned_label, extRefUsed;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [5:0]  srcs [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    logic [15:0] lats [6] = '{16'h0001, 16'h0004, 16'h0004, 16'h0008, 16'h0010, 16'h0020};
    logic [15:0] codes [6] = '{16'h0000, 16'h0000, 16'h0000, `ERR_CODE_DEVICE, `ERR_CODE_EXEC, `ERR_CODE_CMD};
    // event sources and conditions driven as vectors
    assign {opcRequest, readWithoutQuery, dataNotFetched, deviceFault, execFault, cmdFault} = pulses;
    assign {alignment_running, batteryLow, tempSuspect, limitViolated, unaligned_label, extRefUsed} = conds;

    instrument_event_status_regs i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .qryValid(qryValid), .qryWrite(qryWrite), .qrySel(qrySel),
        .qryWdata(qryWdata), .rspValid(rspValid), .rspData(rspData), .opcRequest(opcRequest),
        .allPriorDone(allPriorDone), .readWithoutQuery(readWithoutQuery), .dataNotFetched(dataNotFetched),
        .deviceFault(deviceFault), .execFault(execFault), .cmdFault(cmdFault),
        .alignment_running(alignment_running), .batteryLow(batteryLow), .tempSuspect(tempSuspect),
        .limitViolated(limitViolated), .unaligned_label(unaligned_label), .extRefUsed(extRefUsed),
        .errLogValid(errLogValid), .errLogCode(errLogCode), .eventSummary(eventSummary),
        .suspectSummary(suspectSummary), .activitySummary(activitySummary));
    host_ctrl i_host (
        .clk_sys(clk_sys), .qryValid(qryValid), .qryWrite(qryWrite), .qrySel(qrySel),
        .qryWdata(qryWdata), .rspValid(rspValid), .rspData(rspData));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one query; the answer cycle is fixed, so no wait loop is needed
    task automatic qry(input logic wr, input logic [3:0] sel, input logic [15:0] wd, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        i_host.access(wr, sel, wd, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask
    // one-cycle pulse, log entry seen on the next cycle
    task automatic fire(input logic [5:0] p, input logic [15:0] code);
        @(posedge clk_sys);
        #1;
        pulses = p;
        @(posedge clk_sys);
        #1;
        pulses = 6'h00;
        chk({15'h0000, errLogValid}, {15'h0000, code != 16'h0000});
        chk(errLogCode, code);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        resetn = 1'b0;
        pulses = 6'h00;
        conds = 6'h00;
        allPriorDone = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0080);
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0000);
        qry(1'b1, `SEL_EVT_MASK, 16'hFFFF, 16'h0000);
        qry(1'b0, `SEL_EVT_MASK, 16'h0000, 16'h00FF);
        chk({15'h0000, eventSummary}, 16'h0000);
        // each source alone, summary up until the latch is read
        for (int i = 0; i < 6; i++) begin
            fire(srcs[i], codes[i]);
            chk({15'h0000, eventSummary}, 16'h0001);
            qry(1'b0, `SEL_EVT_LATCH, 16'h0000, lats[i]);
        end
        fire(6'h07, `ERR_CODE_DEVICE);
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0038);
        fire(6'h03, `ERR_CODE_EXEC);
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0030);
        // operation complete held back until earlier commands finish
        allPriorDone = 1'b0;
        fire(6'h20, 16'h0000);
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0000);
        allPriorDone = 1'b1;
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0001);
        qry(1'b1, `SEL_EVT_MASK, 16'h0000, 16'h0000);
        fire(6'h01, `ERR_CODE_CMD);
        chk({15'h0000, eventSummary}, 16'h0000);
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0020);
        // all conditions at once, enables with bit 15 dropped
        conds = 6'h3F;
        qry(1'b1, `SEL_ACT_ENABLE, 16'hFFFF, 16'h0000);
        qry(1'b0, `SEL_ACT_ENABLE, 16'h0000, 16'h7FFF);
        chk({15'h0000, activitySummary}, 16'h0001);
        qry(1'b1, `SEL_SUS_ENABLE, 16'hFFFF, 16'h0000);
        chk({15'h0000, suspectSummary}, 16'h0001);
        qry(1'b0, `SEL_ACT_COND, 16'h0000, 16'h0001);
        qry(1'b0, `SEL_ACT_EVENT, 16'h0000, 16'h0001);
        qry(1'b0, `SEL_ACT_EVENT, 16'h0000, 16'h0000);
        chk({15'h0000, activitySummary}, 16'h0000);
        qry(1'b0, `SEL_SUS_COND, 16'h0000, 16'h0614);
        qry(1'b0, `SEL_SUS_EVENT, 16'h0000, 16'h0614);
        chk({15'h0000, suspectSummary}, 16'h0000);
        qry(1'b0, `SEL_TB_COND, 16'h0000, 16'h0100);
        qry(1'b0, `SEL_TB_EVENT, 16'h0000, 16'h0100);
        qry(1'b0, `SEL_SUS_ENABLE, 16'h0000, 16'h7FFF);
        qry(1'b1, `SEL_TB_ENABLE, 16'hFFFF, 16'h0000);
        qry(1'b0, `SEL_TB_ENABLE, 16'h0000, 16'h7FFF);
        conds = 6'h00;
        qry(1'b0, `SEL_ACT_COND, 16'h0000, 16'h0000);
        qry(1'b0, `SEL_SUS_EVENT, 16'h0000, 16'h0000);
        qry(1'b1, `SEL_SUS_COND, 16'hFFFF, 16'h0000);
        qry(1'b0, `SEL_SUS_COND, 16'h0000, 16'h0000);
        qry(1'b0, 4'hF, 16'h0000, 16'h0000);
        // second power-up mid-run: power-on bit back, mask and timebase enable cleared
        @(posedge clk_sys);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        qry(1'b0, `SEL_EVT_LATCH, 16'h0000, 16'h0080);
        qry(1'b0, `SEL_EVT_MASK, 16'h0000, 16'h0000);
        qry(1'b0, `SEL_TB_ENABLE, 16'h0000, 16'h0000);
        close_out();
    end
endmodule
